// file: src/gpio_touch_shared_ports.sv
/*
  gpio logic for an eight-bit touch-shared port (a) and a three-bit port (b)
  shared with oscillator and reset pins, with an ahb-lite register slave.
  assumes a pad ring resolving out/oe per pin, standby_i from the clock
  controller on clock_i, and a touch sensor that uses touch_en_o.
//
// Summary of operation
// - direction 1 makes the pin an output driven from its latch bit.
// - direction 0 makes the pin an input; latch is not driven.
// - data writes always load the latch; only outputs show it.
// - reading data on an output bit returns the latch bit.
// - input bits read the pin; read-modify-write reads return the latch.
// - reset clears port a direction and touch-disable to zero.
// - touch-disable 0 selects touch input, 1 enables port input.
// - pull-up bit 1 connects the pull-up, 0 disconnects it.
// - a pin driving low always has its pull-up disconnected.
// - standby with pin-state bit 1 floats pins and holds inputs low.
// - touch stop-enable 1 keeps touch inputs live during standby.
// - pin-state bit 0 leaves pins unchanged during standby.
// - open-drain port b pins float when their latch is 1.
// - reset clears port b direction to zero.
*/
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module gpio_touch_shared_ports (
  input wire logic clock_i, // 20 mhz cpu clock
  input wire logic nrst_i, // async reset, active low
  input wire logic hsel_i, // ahb slave select
  input wire logic [7:0] haddr_i, // ahb address, low byte
  input wire logic [1:0] htrans_i, // ahb transfer type
  input wire logic hwrite_i, // ahb write
  input wire logic [2:0] hsize_i, // ahb size, word only
  input wire logic [31:0] hwdata_i, // ahb write data
  input wire logic hready_i, // ahb bus ready
  output logic hreadyout_o, // ahb slave ready
  output logic hresp_o, // ahb response, always okay
  output logic [31:0] hrdata_o, // ahb read data
  input wire logic standby_i, // stop or watch mode active
  input wire logic [7:0] pa_in_i, // port a pad levels
  output logic [7:0] pa_out_o, // port a pad drive value
  output logic [7:0] pa_oe_o, // port a pad drive enable
  output logic [7:0] pa_pullup_o, // port a pull-up connect
  output logic [7:0] touch_en_o, // touch input path live per pin
  input wire logic [2:0] pb_in_i, // port b pad levels
  output logic [2:0] pb_out_o, // port b pad drive value
  output logic [2:0] pb_oe_o // port b pad drive enable
);

  // ============================================================
  // registers
  logic [7:0] pa_data_r;
  logic [7:0] pa_dir_r;
  logic [7:0] pa_pull_r;
  logic [7:0] pa_tdis_r;
  logic [2:0] pb_data_r;
  logic [2:0] pb_dir_r;
  logic pin_state_r;
  logic touch_stop_r;
  gpio_pkg::bus_state_t state_r;
  gpio_pkg::bus_state_t state_nxt;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r;
  logic [7:0] pa_sync;
  logic [2:0] pb_sync;
  logic [7:0] pa_in_eff;
  logic [2:0] pb_in_eff;
  logic blk;
  logic take;
  logic wr_en;

  // ============================================================
  // pin input synchronisers
  pin_sync #(.W(gpio_pkg::PA_W)) u_sync_a (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i(pa_in_i),
    .q_o(pa_sync)
  );

  pin_sync #(.W(gpio_pkg::PB_W)) u_sync_b (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .d_i(pb_in_i),
    .q_o(pb_sync)
  );

  // ============================================================
  // pads
  // blocking only applies with the pin-state bit set
  assign blk = standby_i & pin_state_r;

  genvar gi;
  generate
    for (gi = 0; gi < gpio_pkg::PA_W; gi++) begin : g_pa
      assign pa_out_o[gi] = pa_data_r[gi];
      assign pa_oe_o[gi] = pa_dir_r[gi] & ~blk;
      // pull-up off while driving low or floated in standby
      assign pa_pullup_o[gi] = pa_pull_r[gi] & ~blk
          & ~(pa_oe_o[gi] & ~pa_data_r[gi]);
      // port input only when touch disable is 1; held low when blocked
      assign pa_in_eff[gi] = pa_sync[gi] & pa_tdis_r[gi] & ~blk;
      assign touch_en_o[gi] = ~pa_tdis_r[gi] & ~pa_dir_r[gi]
          & ~(blk & ~touch_stop_r);
    end
    for (gi = 0; gi < gpio_pkg::PB_W; gi++) begin : g_pb
      if (gpio_pkg::PB_OD_MASK[gi]) begin : g_od
        // open drain never drives high: a latch 1 leaves the pad floating
        assign pb_out_o[gi] = 1'b0;
        assign pb_oe_o[gi] = pb_dir_r[gi] & ~pb_data_r[gi] & ~blk;
      end else begin : g_pp
        assign pb_out_o[gi] = pb_data_r[gi];
        assign pb_oe_o[gi] = pb_dir_r[gi] & ~blk;
      end
      assign pb_in_eff[gi] = pb_sync[gi] & ~blk;
    end
  endgenerate

  // ============================================================
  // bus slave
  assign take = hsel_i & hready_i & htrans_i[gpio_pkg::HTRANS_ACTIVE_BIT];
  assign wr_en = (state_r == gpio_pkg::BUS_WRITE);
  assign hreadyout_o = (state_r != gpio_pkg::BUS_READ_WAIT);
  assign hresp_o = gpio_pkg::HRESP_OKAY;
  assign hrdata_o = hrdata_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [31:0] rd_value(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    // output bits read the latch, input bits the pin
    if (hit(a, gpio_pkg::OFS_PA_DATA)) begin
      v[7:0] = (pa_dir_r & pa_data_r) | (~pa_dir_r & pa_in_eff);
    end else if (hit(a, gpio_pkg::OFS_PA_DATA_LAT)) begin
      v[7:0] = pa_data_r;
    end else if (hit(a, gpio_pkg::OFS_PA_DIR)) begin
      v[7:0] = pa_dir_r;
    end else if (hit(a, gpio_pkg::OFS_PA_PULL)) begin
      v[7:0] = pa_pull_r;
    end else if (hit(a, gpio_pkg::OFS_PA_TDIS)) begin
      v[7:0] = pa_tdis_r;
    end else if (hit(a, gpio_pkg::OFS_PB_DATA)) begin
      v[2:0] = (pb_dir_r & pb_data_r) | (~pb_dir_r & pb_in_eff);
    end else if (hit(a, gpio_pkg::OFS_PB_DATA_LAT)) begin
      v[2:0] = pb_data_r;
    end else if (hit(a, gpio_pkg::OFS_PB_DIR)) begin
      v[2:0] = pb_dir_r;
    end else if (hit(a, gpio_pkg::OFS_STBY)) begin
      v[gpio_pkg::PIN_STATE_BIT] = pin_state_r;
    end else if (hit(a, gpio_pkg::OFS_TPSC)) begin
      v[gpio_pkg::TOUCH_STOP_BIT] = touch_stop_r;
    end
    rd_value = v;
  endfunction

  always_comb begin
    state_nxt = gpio_pkg::BUS_IDLE;
    case (state_r)
      gpio_pkg::BUS_READ_WAIT: state_nxt = gpio_pkg::BUS_READ_DONE;
      gpio_pkg::BUS_IDLE,
      gpio_pkg::BUS_WRITE,
      gpio_pkg::BUS_READ_DONE: begin
        if (take) begin
          state_nxt = hwrite_i ? gpio_pkg::BUS_WRITE : gpio_pkg::BUS_READ_WAIT;
        end
      end
      default: state_nxt = gpio_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= gpio_pkg::BUS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_r <= 8'h00;
    end else if (take && hreadyout_o) begin
      addr_r <= haddr_i;
    end
  end

  // one wait state lets a preceding write settle before the read samples
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (state_r == gpio_pkg::BUS_READ_WAIT) begin
      hrdata_r <= rd_value(addr_r);
    end
  end

  // ============================================================
  // register writes; the latch-read alias also writes the latch
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_data_r <= gpio_pkg::RST_PA_DATA;
      pb_data_r <= gpio_pkg::RST_PB_DATA;
    end else if (wr_en) begin
      if (hit(addr_r, gpio_pkg::OFS_PA_DATA) || hit(addr_r, gpio_pkg::OFS_PA_DATA_LAT)) begin
        pa_data_r <= hwdata_i[7:0];
      end
      if (hit(addr_r, gpio_pkg::OFS_PB_DATA) || hit(addr_r, gpio_pkg::OFS_PB_DATA_LAT)) begin
        pb_data_r <= hwdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_dir_r <= gpio_pkg::RST_PA_DIR;
      pa_tdis_r <= gpio_pkg::RST_PA_TDIS;
      pa_pull_r <= gpio_pkg::RST_PA_PULL;
      pb_dir_r <= gpio_pkg::RST_PB_DIR;
    end else if (wr_en) begin
      if (hit(addr_r, gpio_pkg::OFS_PA_DIR)) begin
        pa_dir_r <= hwdata_i[7:0];
      end
      if (hit(addr_r, gpio_pkg::OFS_PA_TDIS)) begin
        pa_tdis_r <= hwdata_i[7:0];
      end
      if (hit(addr_r, gpio_pkg::OFS_PA_PULL)) begin
        pa_pull_r <= hwdata_i[7:0];
      end
      if (hit(addr_r, gpio_pkg::OFS_PB_DIR)) begin
        pb_dir_r <= hwdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_state_r <= gpio_pkg::RST_PIN_STATE;
      touch_stop_r <= gpio_pkg::RST_TOUCH_STOP;
    end else if (wr_en) begin
      if (hit(addr_r, gpio_pkg::OFS_STBY)) begin
        pin_state_r <= hwdata_i[gpio_pkg::PIN_STATE_BIT];
      end
      if (hit(addr_r, gpio_pkg::OFS_TPSC)) begin
        touch_stop_r <= hwdata_i[gpio_pkg::TOUCH_STOP_BIT];
      end
    end
  end

  // ============================================================
  // checks
  logic first_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_read_req;
    take && hreadyout_o && !hwrite_i;
  endsequence

  sequence s_read_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  // address phase of a write to the port a latch
  sequence s_latch_wr;
    take && hwrite_i && haddr_i == gpio_pkg::OFS_PA_DATA;
  endsequence

  a_out_drive: assert property (pa_oe_o == (pa_dir_r & ~{8{blk}}))
    else $error("port a drive enable wrong");
  // data phase follows the address phase; the latch shows the word one edge later
  a_latch_write: assert property (s_latch_wr |-> ##2 (pa_out_o == $past(hwdata_i[7:0])))
    else $error("port a latch not written");
  a_read_timing: assert property (s_read_req |-> ##1 s_read_answer)
    else $error("read answer timing wrong");
  a_read_output: assert property (state_r == gpio_pkg::BUS_READ_DONE
      && addr_r == gpio_pkg::OFS_PA_DATA
      |-> (hrdata_o[7:0] & $past(pa_dir_r)) == ($past(pa_data_r) & $past(pa_dir_r)))
    else $error("output bit read not latch");
  a_rmw_latch: assert property (state_r == gpio_pkg::BUS_READ_DONE
      && addr_r == gpio_pkg::OFS_PB_DATA_LAT |-> hrdata_o == {29'h0, $past(pb_data_r)})
    else $error("latch-read alias not latch");
  a_reset_clear: assert property (first_r |-> pa_dir_r == 8'h00 && pa_tdis_r == 8'h00
      && pb_dir_r == 3'h0)
    else $error("reset defaults wrong");
  a_touch_select: assert property (touch_en_o == (~pa_tdis_r & ~pa_dir_r
      & ~{8{blk & ~touch_stop_r}}))
    else $error("touch path select wrong");
  a_pullup_low: assert property ((pa_pullup_o & pa_oe_o & ~pa_out_o) == 8'h00
      && (pa_pullup_o & ~pa_pull_r) == 8'h00)
    else $error("pull-up connected wrongly");
  a_stop_float: assert property (blk |-> pa_oe_o == 8'h00 && pb_oe_o == 3'h0
      && pa_in_eff == 8'h00 && pb_in_eff == 3'h0)
    else $error("standby pins not floated");
  a_stop_hold: assert property (standby_i && !pin_state_r |-> pb_oe_o == (pb_dir_r
      & ~(gpio_pkg::PB_OD_MASK & pb_data_r)))
    else $error("standby changed pins");
  a_od_float: assert property ((pb_oe_o & gpio_pkg::PB_OD_MASK & pb_data_r) == 3'h0)
    else $error("open drain drove high");
  a_pb_upper_zero: assert property (state_r == gpio_pkg::BUS_READ_DONE
      && (addr_r == gpio_pkg::OFS_PB_DIR || addr_r == gpio_pkg::OFS_PB_DATA)
      |-> hrdata_o[31:3] == 29'h0)
    else $error("port b upper bits not zero");

endmodule

// file: src/gpio_pkg.sv
/*
  constants shared by the two-port gpio block: register offsets, field positions,
  reset values, pin widths and the bus-side state type.
  assumes a 32-bit ahb-lite slave decoding the low address byte only.
*/
package gpio_pkg;

  // ============================================================
  // widths
  localparam int PA_W = 8;
  localparam int PB_W = 3;
  localparam int AW = 8;

  // ============================================================
  // register byte offsets
  localparam logic [7:0] OFS_PA_DATA = 8'h00;
  localparam logic [7:0] OFS_PA_DIR = 8'h04;
  localparam logic [7:0] OFS_PA_PULL = 8'h08;
  localparam logic [7:0] OFS_PA_TDIS = 8'h0c;
  localparam logic [7:0] OFS_PB_DATA = 8'h10;
  localparam logic [7:0] OFS_PB_DIR = 8'h14;
  localparam logic [7:0] OFS_STBY = 8'h18;
  localparam logic [7:0] OFS_TPSC = 8'h1c;
  // alias addresses that read the latch, as a read-modify-write read does
  localparam logic [7:0] OFS_PA_DATA_LAT = 8'h40;
  localparam logic [7:0] OFS_PB_DATA_LAT = 8'h50;

  // ============================================================
  // field positions
  localparam int PIN_STATE_BIT = 0;
  localparam int TOUCH_STOP_BIT = 0;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ============================================================
  // reset values
  localparam logic [7:0] RST_PA_DATA = 8'h00;
  localparam logic [7:0] RST_PA_DIR = 8'h00;
  localparam logic [7:0] RST_PA_PULL = 8'h00;
  localparam logic [7:0] RST_PA_TDIS = 8'h00;
  localparam logic [2:0] RST_PB_DATA = 3'h0;
  localparam logic [2:0] RST_PB_DIR = 3'h0;
  localparam logic RST_PIN_STATE = 1'b0;
  localparam logic RST_TOUCH_STOP = 1'b0;

  // port b pins built as n-channel open drain
  localparam logic [2:0] PB_OD_MASK = 3'h4;
  localparam logic HRESP_OKAY = 1'b0;

  // ============================================================
  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT,
    BUS_READ_DONE
  } bus_state_t;

endpackage

// file: src/pin_sync.sv
/*
  two-flop synchroniser for a group of pin levels.
  assumes the inputs are asynchronous to clock_i and only the output is read.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic clock_i, // block clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [W-1:0] d_i, // raw pin levels
  output logic [W-1:0] q_o // synchronised levels
);

  logic [W-1:0] meta_r;

  // ============================================================
  // first stage feeds only the second
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// file: sim/pin_board.sv
/*
  board-side model of the port pins: resolves each pad level from the block's
  drive, its pull-ups and a board driver that the bench switches on or off.
  assumes the bench keeps the board driver off whenever a pin must float.
*/
`timescale 1ns/1ps
module pin_board (
  input wire logic clock_i, // block clock
  input wire logic ext_en_i, // board driver active
  input wire logic [7:0] pa_ext_i, // board value, port a
  input wire logic [2:0] pb_ext_i, // board value, port b
  input wire logic [7:0] pa_out_i, // block drive value, port a
  input wire logic [7:0] pa_oe_i, // block drive enable, port a
  input wire logic [7:0] pa_pullup_i, // pull-up connect, port a
  input wire logic [2:0] pb_out_i, // block drive value, port b
  input wire logic [2:0] pb_oe_i, // block drive enable, port b
  output logic [7:0] pa_lvl_o, // port a pad level
  output logic [2:0] pb_lvl_o // port b pad level
);
  // ============================================================
  // pad resolution
  // a floating pin toggles every cycle so no read passes by chance
  logic float_r = 1'b0;
  always @(posedge clock_i) begin
    float_r <= ~float_r;
  end
  // board output yields to the block, as shared outputs are off before port use
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pa_oe_i[i]) pa_lvl_o[i] = pa_out_i[i];
      else if (ext_en_i) pa_lvl_o[i] = pa_ext_i[i];
      else if (pa_pullup_i[i]) pa_lvl_o[i] = 1'b1;
      else pa_lvl_o[i] = float_r;
    end
    for (int i = 0; i < 3; i++) begin
      if (pb_oe_i[i]) pb_lvl_o[i] = pb_out_i[i];
      else if (ext_en_i) pb_lvl_o[i] = pb_ext_i[i];
      else pb_lvl_o[i] = float_r;
    end
  end
endmodule

// file: sim/tb.sv
/*
  self-checking bench for the two-port gpio block: ahb-lite register traffic,
  random port setups, pull-ups, standby pin holding and reset values.
  assumes the bus answer timing and register offsets of the block's package.
*/
`timescale 1ns/1ps
module tb;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic standby_i = 1'b0;
  logic ext_en = 1'b1;
  logic [7:0] pa_ext = 8'h00;
  logic [2:0] pb_ext = 3'h0;
  logic hreadyout_o, hresp_o;
  logic [31:0] hrdata_o, rd, rnd;
  logic [7:0] pa_out_o, pa_oe_o, pa_pullup_o, touch_en_o, pa_lvl, dir, lat, tdis, pull;
  logic [2:0] pb_out_o, pb_oe_o, pb_lvl, bdir, blat;
  int n_mismatch = 0;
  int checks = 0;
  integer seed = 32'h7401;
  always #25 clock_i = ~clock_i;

  gpio_touch_shared_ports i_gpio_touch_shared_ports (.clock_i(clock_i), .nrst_i(nrst_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .standby_i(standby_i), .pa_in_i(pa_lvl), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o),
    .pa_pullup_o(pa_pullup_o), .touch_en_o(touch_en_o), .pb_in_i(pb_lvl),
    .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o));
  pin_board i_pin_board (.clock_i(clock_i), .ext_en_i(ext_en), .pa_ext_i(pa_ext),
    .pb_ext_i(pb_ext), .pa_out_i(pa_out_o), .pa_oe_i(pa_oe_o), .pa_pullup_i(pa_pullup_o),
    .pb_out_i(pb_out_o), .pb_oe_i(pb_oe_o), .pa_lvl_o(pa_lvl), .pb_lvl_o(pb_lvl));

  // ============================================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", {31'h0, gpio_pkg::HRESP_OKAY}, {31'h0, hresp_o});
    @(negedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // input bits read the pad only where port input is enabled
  function automatic logic [7:0] exp_rd(input logic [7:0] d, l, en, p);
    return (d & l) | (~d & en & p);
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic stby(input logic v);
    @(posedge clock_i);
    standby_i <= v;
    @(negedge clock_i);
  endtask

  // ============================================================
  // watchdog, far longer than the whole sequence
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    complete_run();
  end

  // ============================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    chk("oe_a", 32'h0, {24'h0, pa_oe_o});
    chk("touch_en", 32'hff, {24'h0, touch_en_o});
    chk("oe_b", 32'h0, {29'h0, pb_oe_o});
    rdc(gpio_pkg::OFS_PA_DIR, 32'h0, "dir_a");
    rdc(gpio_pkg::OFS_PA_TDIS, 32'h0, "tdis_a");
    rdc(gpio_pkg::OFS_PB_DIR, 32'h0, "dir_b");
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      dir = 8'($random(seed));
      lat = 8'($random(seed));
      tdis = (k == 0) ? 8'h00 : 8'($random(seed));
      pull = 8'($random(seed));
      pa_ext = 8'($random(seed));
      pb_ext = 3'($random(seed));
      wr(gpio_pkg::OFS_PA_DATA, {24'h0, lat});
      wr(gpio_pkg::OFS_PA_DIR, {24'h0, dir});
      wr(gpio_pkg::OFS_PA_PULL, {24'h0, pull});
      wr(gpio_pkg::OFS_PA_TDIS, {24'h0, tdis});
      chk("out_a", {24'h0, lat}, {24'h0, pa_out_o});
      chk("oe_a", {24'h0, dir}, {24'h0, pa_oe_o});
      chk("pull_a", {24'h0, pull & ~(dir & ~lat)}, {24'h0, pa_pullup_o});
      chk("touch_en", {24'h0, ~tdis & ~dir}, {24'h0, touch_en_o});
      repeat (3) @(negedge clock_i);
      rdc(gpio_pkg::OFS_PA_DATA, {24'h0, exp_rd(dir, lat, tdis, pa_ext)}, "rd_a");
      rdc(gpio_pkg::OFS_PA_DATA_LAT, {24'h0, lat}, "latrd_a");
      rnd = $random(seed);
      blat = rnd[2:0];
      wr(gpio_pkg::OFS_PB_DATA, rnd);
      rnd = $random(seed);
      bdir = rnd[2:0];
      wr(gpio_pkg::OFS_PB_DIR, rnd);
      chk("oe_b", {29'h0, bdir & ~(blat & gpio_pkg::PB_OD_MASK)}, {29'h0, pb_oe_o});
      chk("out_b", {29'h0, blat & ~gpio_pkg::PB_OD_MASK}, {29'h0, pb_out_o});
      rdc(gpio_pkg::OFS_PB_DIR, {29'h0, bdir}, "dir_b");
      rdc(gpio_pkg::OFS_PB_DATA_LAT, {29'h0, blat}, "latrd_b");
      rdc(gpio_pkg::OFS_PB_DATA, {29'h0, (bdir & blat) | (~bdir & pb_ext)}, "rd_b");
    end
    $display("test random ports done");
    ext_en = 1'b0;
    wr(gpio_pkg::OFS_PA_DIR, 32'h0);
    wr(gpio_pkg::OFS_PA_TDIS, 32'hff);
    wr(gpio_pkg::OFS_PA_PULL, 32'hff);
    repeat (3) @(negedge clock_i);
    rdc(gpio_pkg::OFS_PA_DATA, 32'hff, "pulled_a");
    wr(8'h30, 32'hffffffff);
    rdc(8'h30, 32'h0, "unmapped");
    $display("test pull-up and unmapped done");
    ext_en = 1'b1;
    pa_ext = 8'hff;
    wr(gpio_pkg::OFS_PA_DATA, 32'h0);
    wr(gpio_pkg::OFS_PA_DIR, 32'h0f);
    wr(gpio_pkg::OFS_PA_TDIS, 32'h30);
    wr(gpio_pkg::OFS_PB_DIR, 32'h3);
    wr(gpio_pkg::OFS_STBY, 32'h1);
    wr(gpio_pkg::OFS_TPSC, 32'h0);
    stby(1'b1);
    chk("oe_a", 32'h0, {24'h0, pa_oe_o});
    chk("oe_b", 32'h0, {29'h0, pb_oe_o});
    chk("touch_en", 32'h0, {24'h0, touch_en_o});
    chk("pull_a", 32'h0, {24'h0, pa_pullup_o});
    repeat (3) @(negedge clock_i);
    rdc(gpio_pkg::OFS_PA_DATA, 32'h0, "held_a");
    stby(1'b0);
    wr(gpio_pkg::OFS_TPSC, 32'h1);
    stby(1'b1);
    chk("touch_en", 32'hc0, {24'h0, touch_en_o});
    stby(1'b0);
    wr(gpio_pkg::OFS_STBY, 32'h0);
    stby(1'b1);
    chk("oe_a", 32'h0f, {24'h0, pa_oe_o});
    chk("out_a", 32'h0, {24'h0, pa_out_o});
    chk("oe_b", 32'h3, {29'h0, pb_oe_o});
    chk("pull_a", 32'hf0, {24'h0, pa_pullup_o});
    stby(1'b0);
    $display("test standby done");
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    chk("oe_a", 32'h0, {24'h0, pa_oe_o});
    chk("oe_b", 32'h0, {29'h0, pb_oe_o});
    chk("touch_en", 32'hff, {24'h0, touch_en_o});
    $display("test second reset done");
    complete_run();
  end
endmodule
